// *** hw/timer_interrupt_status.v ***
// event status, mask and clear registers of a general-purpose timer, on an ahb-lite slave port
// assumes events arrive as one-cycle pulses from logic clocked by hclk, one slave on the bus
//
// Functional notes
// - Each raw status bit is set by its event whatever the mask bit says.
// - Writing a one to a bit of the clear register clears that raw status bit.
// - A masked status bit reads one only when its mask bit and raw bit are both set.
// - Writing a one to a bit of the clear register clears that masked status bit too.
// - The first sub-timer time-out is raw bit 0, read-only, reset zero.
// - The first sub-timer capture match is raw bit 1, read-only, reset zero.
// - The first sub-timer capture edge is raw bit 2, read-only, reset zero.
// - The clock-alarm match is raw bit 3, read-only, reset zero.
// - The second sub-timer time-out is raw bit 8, read-only, reset zero.
// - The second sub-timer capture match is raw bit 9, read-only, reset zero.
// - The second sub-timer capture edge is raw bit 10, read-only, reset zero.
// - Masked bits sit at the raw positions 0 to 3 and 8 to 10, read-only, reset zero.
// - Bits 31:11 and 7:4 of both status registers read zero; software keeps them.
// - The mask register holds one enable per source at the status positions, one enables.
// - A zero written to any clear bit leaves the status bits unchanged.
`include "timer_irq_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module timer_interrupt_status (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire first_timeout_event,
	input wire first_capture_match_event,
	input wire first_capture_edge_event,
	input wire clock_alarm_event,
	input wire second_timeout_event,
	input wire second_capture_match_event,
	input wire second_capture_edge_event,
	output reg timer_irq
);

	reg [10:0] raw_status_reg;
	reg [10:0] raw_status_next;
	reg [10:0] event_mask_register_reg;
	reg [10:0] event_mask_next;
	reg wr_pending_reg;
	reg [`ADDR_BITS-1:0] wr_addr_reg;
	wire [10:0] event_vec;
	wire [10:0] masked_status;
	wire [10:0] clear_vec;
	wire addr_phase;
	wire [`ADDR_BITS-1:0] word_addr;

	// the slave never stretches a transfer and never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign addr_phase = hsel & hready & htrans[1];
	assign word_addr = {haddr[`ADDR_BITS-1:2], 2'b00};

	// event inputs gathered at their status positions; unused positions stay zero
	assign event_vec[`BIT_FIRST_TIMEOUT] = first_timeout_event;
	assign event_vec[`BIT_FIRST_CAP_MATCH] = first_capture_match_event;
	assign event_vec[`BIT_FIRST_CAP_EDGE] = first_capture_edge_event;
	assign event_vec[`BIT_CLOCK_ALARM] = clock_alarm_event;
	assign event_vec[7:4] = 4'h0;
	assign event_vec[`BIT_SECOND_TIMEOUT] = second_timeout_event;
	assign event_vec[`BIT_SECOND_CAP_MATCH] = second_capture_match_event;
	assign event_vec[`BIT_SECOND_CAP_EDGE] = second_capture_edge_event;

	// masked view is derived, so one clear serves both registers
	assign masked_status = raw_status_reg & event_mask_register_reg;

	// clear strobe exists only in the data phase of a write to the clear register
	assign clear_vec = (wr_pending_reg && wr_addr_reg == `OFF_EVENT_CLEAR) ?
		(hwdata[10:0] & `EVENT_BITS_MASK) : 11'h000;

	// address phase capture for writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else begin
			wr_pending_reg <= addr_phase & hwrite;
			wr_addr_reg <= word_addr;
		end
	end

	// sticky status: set wins over a clear in the same cycle so no event is lost
	// next mask is formed here too, so the interrupt follows a mask write on the same edge
	always @* begin
		raw_status_next = (raw_status_reg & ~clear_vec) | event_vec;
		event_mask_next = event_mask_register_reg;
		// writes to the status offsets fall through untouched
		if (wr_pending_reg && wr_addr_reg == `OFF_EVENT_MASK) begin
			event_mask_next = hwdata[10:0] & `EVENT_BITS_MASK;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_status_reg <= `EVENT_RESET;
			event_mask_register_reg <= `EVENT_RESET;
			timer_irq <= 1'b0;
		end else begin
			raw_status_reg <= raw_status_next & `EVENT_BITS_MASK;
			event_mask_register_reg <= event_mask_next;
			timer_irq <= |(raw_status_next & event_mask_next);
		end
	end

	// read data is registered at the address phase, so it stands during the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			case (word_addr)
				`OFF_EVENT_MASK: hrdata <= {21'h00_0000, event_mask_register_reg};
				`OFF_RAW_STATUS: hrdata <= {21'h00_0000, raw_status_reg};
				`OFF_MASKED_STATUS: hrdata <= {21'h00_0000, masked_status};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** hw/timer_irq_regs.vh ***
// register offsets, field positions and reset values of the timer event status block
// assumes a 32-bit word bus with byte addresses, one aligned word per register
`ifndef TIMER_IRQ_REGS_VH
`define TIMER_IRQ_REGS_VH

// byte offsets
`define OFF_EVENT_MASK 12'h018
`define OFF_RAW_STATUS 12'h01c
`define OFF_MASKED_STATUS 12'h020
`define OFF_EVENT_CLEAR 12'h024

// event bit positions
`define BIT_FIRST_TIMEOUT 0
`define BIT_FIRST_CAP_MATCH 1
`define BIT_FIRST_CAP_EDGE 2
`define BIT_CLOCK_ALARM 3
`define BIT_SECOND_TIMEOUT 8
`define BIT_SECOND_CAP_MATCH 9
`define BIT_SECOND_CAP_EDGE 10

// implemented bits: 10:8 and 3:0; 31:11 and 7:4 read zero
`define EVENT_BITS_MASK 11'h070f
`define EVENT_RESET 11'h0000
`define ADDR_BITS 12

`endif

// *** tb/timer_interrupt_status_tb.sv ***
// bench: events, mask and clears over the bus, self-checking
// assumes one slave; every phase still waits on hready
`timescale 1ns/100ps
`default_nettype none
module timer_interrupt_status_tb;
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hready, hresp, timer_irq;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [32:0] e = '0;
	logic [10:0] ev = '0;
	int n_mismatch = 0, n_tests = 0;
	always #10 hclk = ~hclk;
	timer_interrupt_status DUT (.*, .hsize(3'h2), .hreadyout(hready),
		.first_timeout_event(ev[0]), .first_capture_match_event(ev[1]),
		.first_capture_edge_event(ev[2]), .clock_alarm_event(ev[3]),
		.second_timeout_event(ev[8]), .second_capture_match_event(ev[9]),
		.second_capture_edge_event(ev[10]));
	// one transfer; a read compares {irq, data} at the edge closing its data phase
	task xf(input [11:0] a, input w, input [32:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite, ev, haddr} <= {3'h6, w, 11'h0, 20'h0, a};
		do @(posedge hclk); while (hready !== 1'h1);
		{hsel, htrans, hwdata} <= {3'h0, d[31:0]};
		do @(posedge hclk); while (hready !== 1'h1);
		n_tests += !w;
		if (!w && {timer_irq, hrdata} !== d) begin
			n_mismatch++;
			$display("ERROR %0t read %h want %h", $time, {timer_irq, hrdata}, d);
		end
	endtask
	// each event pulses once with the mask clear; raw grows, irq stays low
	task t_events;
		int b[7] = '{0, 1, 2, 3, 8, 9, 10};
		xf(12'h018, 1'h0, 33'h0);
		foreach (b[i]) begin
			@(posedge hclk);
			ev <= 11'h1 << b[i];
			e[b[i]] = 1'h1;
			xf(12'h01c, 1'h0, e);
		end
		xf(12'h020, 1'h0, 33'h0);
		$display("t_events done");
	endtask
	task t_mask;
		xf(12'h018, 1'h1, 33'h0_ffff_ffff);
		xf(12'h018, 1'h0, 33'h1_0000_070f);
		xf(12'h01c, 1'h1, 33'h0);
		xf(12'h024, 1'h1, 33'h0_ffff_f8f0);
		xf(12'h020, 1'h0, 33'h1_0000_070f);
		xf(12'h024, 1'h1, 33'h0_0000_0001);
		xf(12'h020, 1'h0, 33'h1_0000_070e);
		xf(12'h018, 1'h1, 33'h0);
		xf(12'h020, 1'h0, 33'h0);
		$display("t_mask done");
	endtask
	task end_of_test(input int late);
		n_mismatch += late;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog: the tests need about 63 cycles
	initial #20000 end_of_test(1);
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		t_events;
		t_mask;
		end_of_test(0);
	end
endmodule
`default_nettype wire

// *** tb/tis_props.sv ***
// checker of the status slave: spare bits, event capture, interrupt hold
// assumes hready is tied to hreadyout
`timescale 1ns/100ps
`default_nettype none
module tis_props (input wire hclk, hresetn, hsel, hready, hwrite, timer_irq, hresp,
	first_timeout_event, clock_alarm_event, second_capture_edge_event,
	input wire [1:0] htrans, input wire [31:0] haddr, hrdata);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// rr: raw read taken; sp: spare bits of the read word are zero
	wire rd = hsel & hready & htrans[1] & !hwrite;
	wire rr = rd & (haddr[11:2] == 10'h007);
	wire sp = ~|{hrdata[31:11], hrdata[7:4]};
	reg wp;
	// write data phase, the only place where the interrupt may drop
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) wp <= 1'b0;
		else wp <= hsel & hready & htrans[1] & hwrite;
	end
	property p_rk; rd && haddr[11:2] == 10'h006 |=> sp; endproperty
	a_rk: assert property (p_rk) else $error("mask spare bits set");
	property p_rr; rr |=> sp; endproperty
	a_rr: assert property (p_rr) else $error("raw spare bits set");
	property p_rm; rd && haddr[11:2] == 10'h008 |=> sp; endproperty
	a_rm: assert property (p_rm) else $error("masked spare bits set");
	property p_hold; timer_irq && !wp |=> timer_irq; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	property p_rst; $rose(hresetn) |-> !timer_irq; endproperty
	a_rst: assert property (p_rst) else $error("irq after reset");
	property p_e0; first_timeout_event ##1 rr && !wp |=> hrdata[0]; endproperty
	a_e0: assert property (p_e0) else $error("bit 0 lost");
	property p_e3; clock_alarm_event ##1 rr && !wp |=> hrdata[3]; endproperty
	a_e3: assert property (p_e3) else $error("bit 3 lost");
	property p_e10; second_capture_edge_event ##1 rr && !wp |=> hrdata[10]; endproperty
	a_e10: assert property (p_e10) else $error("bit 10 lost");
	property p_okay; hready && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("slave stalled or errored");
endmodule
bind timer_interrupt_status tis_props u_props (.*);
`default_nettype wire
